// ### hdl/itd_core.sv
// execution of immediate transfer forms: pointers, addresses, memory and register writes
`timescale 1ns/1ps
module itd_core
    import itd_pkg::*;
(
    input  wire logic                         mclk_i,
    input  wire logic                         rst_i,
    input  wire logic                         op_valid_i,
    input  wire logic [itd_pkg::OP_W-1:0]     op_i,
    input  wire logic                         dual_mode_i,
    input  wire logic [itd_pkg::WORD_W-1:0]   xfer_wdata_x_i,
    input  wire logic [itd_pkg::WORD_W-1:0]   xfer_wdata_y_i,
    input  wire logic                         ureg_wide_i,
    input  wire logic                         ureg_has_comp_i,
    input  wire logic                         mod_load_i,
    input  wire logic                         mod_load_dag_two_i,
    input  wire logic [itd_pkg::IDX_W-1:0]    mod_load_sel_i,
    input  wire logic [itd_pkg::ADDR_W-1:0]   mod_load_val_i,
    output logic                              mem_en_x_o,
    output logic                              mem_en_y_o,
    output logic                              mem_we_o,
    output logic                              mem_prog_o,
    output logic                              mem_long_o,
    output logic [itd_pkg::ADDR_W-1:0]        mem_addr_x_o,
    output logic [itd_pkg::ADDR_W-1:0]        mem_addr_y_o,
    output logic [itd_pkg::WORD_W-1:0]        mem_wdata_x_o,
    output logic [itd_pkg::WORD_W-1:0]        mem_wdata_y_o,
    output logic                              ureg_we_x_o,
    output logic                              ureg_we_y_o,
    output logic [itd_pkg::UREG_W-1:0]        ureg_num_o,
    output logic [itd_pkg::WORD_W-1:0]        ureg_data_o,
    output logic [itd_pkg::ADDR_W-1:0]        ptr_dag_one_o [8],
    output logic [itd_pkg::ADDR_W-1:0]        ptr_dag_two_o [8]
);
    itd_form_t               form;
    logic [ADDR_W-1:0]       imm;
    logic [IDX_W-1:0]        ptr_sel;
    logic [IDX_W-1:0]        mod_sel;
    logic [UREG_W-1:0]       ureg;
    logic                    prog_space;
    logic                    write;
    logic                    long_word_access;
    logic                    dag_two;
    logic [ADDR_W-1:0]       ptr [2][8];
    logic [ADDR_W-1:0]       modv [2][8];
    logic [ADDR_W-1:0]       ptr_val;
    logic [ADDR_W-1:0]       mod_val;
    logic [ADDR_W-1:0]       next_addr;
    logic [WORD_W-1:0]       imm_word;

    itd_field_decode u_dec (
        .op_i         (op_i),
        .form_o       (form),
        .imm_o        (imm),
        .ptr_sel_o    (ptr_sel),
        .mod_sel_o    (mod_sel),
        .ureg_o       (ureg),
        .prog_space_o (prog_space),
        .write_o      (write),
        .long_o       (long_word_access),
        .dag_two_o    (dag_two)
    );

    function automatic logic in_normal_range(input logic [ADDR_W-1:0] a);
        in_normal_range = (a >= NORMAL_BASE) && (a < NORMAL_END);
    endfunction : in_normal_range

    function automatic logic is_mem_form(input itd_form_t f);
        is_mem_form = (f == ITD_XFER) || (f == ITD_IMEM);
    endfunction : is_mem_form

    assign ptr_val  = ptr[dag_two][ptr_sel];
    assign mod_val  = modv[dag_two][mod_sel];
    assign imm_word = {imm, {PAD_W{1'b0}}}; // [RULE4] [RULE8]

    // pre-modify for transfer, plain pointer for immediate write
    always_comb
    begin
        next_addr = ptr_val;
        if (form == ITD_XFER)
        begin
            next_addr = ptr_val + imm; // [RULE11]
        end
    end

    // pointer update: only the immediate write form writes back
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_dag
            for (genvar r = 0; r < 8; r++)
            begin : g_reg
                always_ff @(posedge mclk_i)
                begin
                    if (rst_i)
                    begin
                        ptr[g][r] <= PTR_RESET;
                    end
                    else if (op_valid_i && form == ITD_IMEM && dag_two == 1'(g) && ptr_sel == IDX_W'(r))
                    begin
                        ptr[g][r] <= ptr_val + mod_val; // [RULE5] [RULE6]
                    end
                end
                always_ff @(posedge mclk_i)
                begin
                    if (rst_i)
                    begin
                        modv[g][r] <= PTR_RESET;
                    end
                    else if (mod_load_i && mod_load_dag_two_i == 1'(g) && mod_load_sel_i == IDX_W'(r))
                    begin
                        modv[g][r] <= mod_load_val_i;
                    end
                end
                // each output element gets exactly one driver
                if (g == 0)
                begin : g_one
                    assign ptr_dag_one_o[r] = ptr[0][r];
                end
                else
                begin : g_two
                    assign ptr_dag_two_o[r] = ptr[1][r];
                end
            end
        end
    endgenerate

    // memory strobes: one cycle after the execute edge
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mem_en_x_o <= 1'b0;
            mem_en_y_o <= 1'b0;
        end
        else
        begin
            mem_en_x_o <= op_valid_i && is_mem_form(form); // [RULE1] [RULE7]
            // second element only when mode bit set at execution
            mem_en_y_o <= op_valid_i && dual_mode_i && is_mem_form(form); // [RULE13] [RULE6]
        end
    end

    // access attributes hold until the next instruction
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mem_we_o   <= 1'b0;
            mem_prog_o <= 1'b0;
            mem_long_o <= 1'b0;
        end
        else if (op_valid_i)
        begin
            mem_we_o   <= write; // [RULE2]
            mem_prog_o <= prog_space; // [RULE2]
            // long override only matters inside the normal-word window
            mem_long_o <= (form == ITD_XFER) && long_word_access && in_normal_range(next_addr); // [RULE3]
        end
    end

    // addresses: second element skewed by one word
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mem_addr_x_o <= '0;
            mem_addr_y_o <= '0;
        end
        else if (op_valid_i)
        begin
            mem_addr_x_o <= next_addr;
            mem_addr_y_o <= next_addr + 32'h0000_0001; // [RULE6]
        end
    end

    // write data: immediate word or the register file's values
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mem_wdata_x_o <= '0;
            mem_wdata_y_o <= '0;
        end
        else if (op_valid_i)
        begin
            if (form == ITD_IMEM)
            begin
                mem_wdata_x_o <= imm_word; // [RULE4]
                mem_wdata_y_o <= imm_word;
            end
            else
            begin
                mem_wdata_x_o <= xfer_wdata_x_i;
                mem_wdata_y_o <= xfer_wdata_y_i;
            end
        end
    end

    // universal register write strobes
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ureg_we_x_o <= 1'b0;
            ureg_we_y_o <= 1'b0;
        end
        else
        begin
            ureg_we_x_o <= op_valid_i && form == ITD_IREG; // [RULE8]
            // registers without a partner act as single mode
            ureg_we_y_o <= op_valid_i && form == ITD_IREG && dual_mode_i && ureg_has_comp_i; // [RULE9] [RULE13]
        end
    end

    // universal register number and data
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ureg_num_o  <= '0;
            ureg_data_o <= '0;
        end
        else if (op_valid_i)
        begin
            ureg_num_o  <= ureg;
            // narrow registers take the raw 32 bits low
            ureg_data_o <= ureg_wide_i ? imm_word : {{PAD_W{1'b0}}, imm}; // [RULE8]
        end
    end
endmodule : itd_core

// ### hdl/itd_field_decode.sv
// field extraction for the three immediate forms
`timescale 1ns/1ps
module itd_field_decode
    import itd_pkg::*;
(
    input  wire logic [itd_pkg::OP_W-1:0]   op_i,
    output itd_pkg::itd_form_t              form_o,
    output logic [itd_pkg::ADDR_W-1:0]      imm_o,
    output logic [itd_pkg::IDX_W-1:0]       ptr_sel_o,
    output logic [itd_pkg::IDX_W-1:0]       mod_sel_o,
    output logic [itd_pkg::UREG_W-1:0]      ureg_o,
    output logic                            prog_space_o,
    output logic                            write_o,
    output logic                            long_o,
    output logic                            dag_two_o
);
    // immediate is carried as upper 8 and lower 24 bits; same place in every form
    assign imm_o = {op_i[IMM_HI_POS +: PAD_W], op_i[0 +: IMM_LO_W]}; // [RULE10]

    always_comb
    begin
        form_o       = ITD_NONE;
        ptr_sel_o    = '0;
        mod_sel_o    = '0;
        ureg_o       = '0;
        prog_space_o = 1'b0;
        write_o      = 1'b0;
        long_o       = 1'b0;
        if (op_i[TOP_POS +: 3] == TOP_XFER)
        begin
            form_o       = ITD_XFER; // [RULE1]
            prog_space_o = op_i[X_G_POS]; // [RULE2]
            ptr_sel_o    = op_i[X_I_POS +: IDX_W];
            write_o      = op_i[X_D_POS]; // [RULE2]
            long_o       = op_i[X_L_POS];
            ureg_o       = {1'b0, op_i[X_UREG_POS +: UREG_W-1]};
        end
        else if (op_i[TOP_POS +: 3] == TOP_IMEM)
        begin
            form_o       = ITD_IMEM; // [RULE7]
            ptr_sel_o    = op_i[M_I_POS +: IDX_W];
            mod_sel_o    = op_i[M_M_POS +: IDX_W];
            prog_space_o = op_i[M_G_POS];
            write_o      = 1'b1;
        end
        // top two bits must be clear too, or 110 opcodes would alias onto this form
        else if (op_i[TOP_POS+1 +: 2] == 2'h0 && op_i[IREG_TOP_POS +: 6] == TOP_IREG)
        begin
            form_o = ITD_IREG; // [RULE10]
            ureg_o = {1'b0, op_i[R_UREG_POS +: UREG_W-1]};
        end
    end
    // program space pointers live in the second address generator
    assign dag_two_o = prog_space_o;
endmodule : itd_field_decode

// ### hdl/itd_pkg.sv
// constants and types for the immediate transfer decoder
// Functional notes
// [RULE1] top bits 101 mark indirect transfer; extract space, pointer, direction, long, ureg, modify
// [RULE2] one bit picks read or write, another picks data or program space
// [RULE3] long bit forces long-word access only when address lies in normal-word range
// [RULE4] immediate-to-memory writes data into upper 32 bits, low 8 bits zero
// [RULE5] immediate-to-memory post-modifies pointer by modify register and writes it back
// [RULE6] dual mode writes both elements; second uses pointer plus one; one post-modify
// [RULE7] top bits 100 mark immediate-to-memory; extract pointer, modify, space, immediate
// [RULE8] immediate-to-register loads 32 bits; 40-bit registers get value high, low 8 zero
// [RULE9] dual mode also writes complementary register; others act as single mode
// [RULE10] immediate-to-register yields register number and 32-bit immediate from two parts
// [RULE11] indirect transfer pre-modifies pointer by immediate; pointer not written back
// [RULE12] software must not use a transfer register from the pointer's own generator
// [RULE13] single or dual behaviour chosen by mode bit sampled at execution
package itd_pkg;
    localparam int OP_W         = 48;
    localparam int ADDR_W       = 32;
    localparam int WORD_W       = 40;
    localparam int PAD_W        = 8;
    localparam int IMM_HI_POS   = 24;
    localparam int IMM_LO_W     = 24;
    localparam int TOP_POS      = 45;
    localparam int IDX_W        = 3;
    localparam int UREG_W       = 8;
    localparam logic [2:0] TOP_XFER = 3'h5;
    localparam logic [2:0] TOP_IMEM = 3'h4;
    localparam logic [5:0] TOP_IREG = 6'h0f;
    localparam int IREG_TOP_POS = 40;
    // indirect transfer field positions
    localparam int X_G_POS      = 44;
    localparam int X_I_POS      = 41;
    localparam int X_D_POS      = 40;
    localparam int X_L_POS      = 39;
    localparam int X_UREG_POS   = 32;
    // immediate-to-memory field positions
    localparam int M_G_POS      = 37;
    localparam int M_M_POS      = 38;
    localparam int M_I_POS      = 41;
    // immediate-to-register field positions
    localparam int R_UREG_POS   = 32;
    localparam logic [ADDR_W-1:0] PTR_RESET   = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] LONG_BASE   = 32'h0004_0000;
    localparam logic [ADDR_W-1:0] NORMAL_BASE = 32'h0008_0000;
    localparam logic [ADDR_W-1:0] NORMAL_END  = 32'h0010_0000;
    typedef enum logic [1:0] {ITD_NONE, ITD_XFER, ITD_IMEM, ITD_IREG} itd_form_t;
endpackage : itd_pkg

// ### test/itd_core_props.sv
// port checker for the immediate transfer core
`timescale 1ns/1ps
module itd_core_props
    import itd_pkg::*;
(
    input  wire logic                         mclk_i,
    input  wire logic                         rst_i,
    input  wire logic                         op_valid_i,
    input  wire logic [itd_pkg::OP_W-1:0]     op_i,
    input  wire logic                         dual_mode_i,
    input  wire logic                         ureg_wide_i,
    input  wire logic                         ureg_has_comp_i,
    input  wire logic                         mem_en_x_o,
    input  wire logic                         mem_en_y_o,
    input  wire logic                         mem_we_o,
    input  wire logic                         mem_prog_o,
    input  wire logic                         mem_long_o,
    input  wire logic [itd_pkg::ADDR_W-1:0]   mem_addr_x_o,
    input  wire logic [itd_pkg::ADDR_W-1:0]   mem_addr_y_o,
    input  wire logic [itd_pkg::WORD_W-1:0]   mem_wdata_x_o,
    input  wire logic                         ureg_we_x_o,
    input  wire logic                         ureg_we_y_o,
    input  wire logic [itd_pkg::WORD_W-1:0]   ureg_data_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_imem;
        op_valid_i && op_i[47:45] == TOP_IMEM;
    endsequence
    sequence s_xfer;
        op_valid_i && op_i[47:45] == TOP_XFER;
    endsequence
    sequence s_ireg;
        op_valid_i && op_i[47:46] == 2'h0 && op_i[45:40] == TOP_IREG;
    endsequence
    a_unknown_refused: assert property (op_valid_i && op_i[47:46] == 2'h3 |=> !mem_en_x_o && !ureg_we_x_o)
        else $error("enable after unknown opcode");
    a_imem_zero_pad: assert property (s_imem |=> mem_en_x_o && mem_we_o
        && mem_wdata_x_o == {$past(op_i[31:0]), 8'h00}) else $error("immediate memory word wrong");
    a_imem_dual_skew: assert property (s_imem ##0 dual_mode_i |=> mem_en_y_o
        && mem_addr_y_o == mem_addr_x_o + 32'h0000_0001) else $error("second element address wrong");
    a_single_mode_quiet: assert property (!dual_mode_i |=> !mem_en_y_o && !ureg_we_y_o)
        else $error("second element active in single mode");
    a_xfer_dir_space: assert property (s_xfer |=> mem_en_x_o && mem_we_o == $past(op_i[40])
        && mem_prog_o == $past(op_i[44])) else $error("transfer direction or space wrong");
    a_xfer_long_range: assert property (s_xfer |=> mem_long_o == ($past(op_i[39])
        && mem_addr_x_o >= NORMAL_BASE && mem_addr_x_o < NORMAL_END)) else $error("long access wrong");
    a_ireg_wide_load: assert property (s_ireg ##0 ureg_wide_i |=> ureg_we_x_o
        && ureg_data_o == {$past(op_i[31:0]), 8'h00}) else $error("wide register load wrong");
    a_ireg_comp_write: assert property (s_ireg ##0 dual_mode_i |=> ureg_we_y_o == $past(ureg_has_comp_i))
        else $error("complementary write wrong");
endmodule : itd_core_props
bind itd_core itd_core_props props_u (.mclk_i, .rst_i, .op_valid_i, .op_i, .dual_mode_i, .ureg_wide_i, .ureg_has_comp_i,
    .mem_en_x_o, .mem_en_y_o, .mem_we_o, .mem_prog_o, .mem_long_o, .mem_addr_x_o, .mem_addr_y_o, .mem_wdata_x_o,
    .ureg_we_x_o, .ureg_we_y_o, .ureg_data_o);

// ### test/tb_top.sv
// self-checking bench for the immediate transfer core
`timescale 1ns/1ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_top;
    import itd_pkg::*;
    typedef struct {int f; logic d, c, we, lg; logic [31:0] ax, im; logic [39:0] wx, wy; logic [7:0] un;} itd_exp_t;
    logic mclk_i = 0, rst_i = 1, op_valid_i = 0, dual_mode_i = 0, ureg_wide_i = 0, ureg_has_comp_i = 0;
    logic mod_load_i = 0, mod_load_dag_two_i = 0, mem_en_x_o, mem_en_y_o, mem_we_o, mem_prog_o, mem_long_o;
    logic ureg_we_x_o, ureg_we_y_o;
    logic [OP_W-1:0] op_i = '0;
    logic [WORD_W-1:0] xfer_wdata_x_i = '0, xfer_wdata_y_i = '0, mem_wdata_x_o, mem_wdata_y_o, ureg_data_o;
    logic [IDX_W-1:0] mod_load_sel_i = '0, ix;
    logic [UREG_W-1:0] ureg_num_o;
    logic [31:0] mod_load_val_i = '0, mem_addr_x_o, mem_addr_y_o, ptr_dag_one_o[8], ptr_dag_two_o[8];
    logic [31:0] rnd = 32'h0000_0010, r2, mp[2][8] = '{default: '0}, pp[2][8] = '{default: '0}, sp[2][8];
    int n_fail = 0, n_tests = 0, g;
    itd_exp_t e, eq[$];
    always #12.5 mclk_i = ~mclk_i;
    itd_core dut_u (.mclk_i, .rst_i, .op_valid_i, .op_i, .dual_mode_i, .xfer_wdata_x_i, .xfer_wdata_y_i, .ureg_wide_i,
        .ureg_has_comp_i, .mod_load_i, .mod_load_dag_two_i, .mod_load_sel_i, .mod_load_val_i, .mem_en_x_o, .mem_en_y_o,
        .mem_we_o, .mem_prog_o, .mem_long_o, .mem_addr_x_o, .mem_addr_y_o, .mem_wdata_x_o, .mem_wdata_y_o, .ureg_we_x_o,
        .ureg_we_y_o, .ureg_num_o, .ureg_data_o, .ptr_dag_one_o, .ptr_dag_two_o);
    // sixteen shifts per call, so consecutive draws share half their bits
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 16; i++)
            s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction : lfsr
    task automatic stop_test;
        $display("checks %0d wrong %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic ptr_cmp;
        foreach (sp[a, b]) `CK(a ? ptr_dag_two_o[b] : ptr_dag_one_o[b], sp[a][b])
    endtask : ptr_cmp
    task automatic check(input itd_exp_t x);
        `CK(mem_en_x_o, x.f == 1 || x.f == 2)
        `CK(mem_en_y_o, (x.f == 1 || x.f == 2) && x.d)
        if (x.f != 1)
            `CK({ureg_we_x_o, ureg_we_y_o}, {x.f == 3, x.f == 3 && x.d && x.c})
        if (x.f == 1 || x.f == 2)
        begin
            `CK({mem_we_o, mem_prog_o, mem_addr_x_o}, {x.we, x.un[7], x.ax})
            if (x.d)
                `CK(mem_addr_y_o, x.ax + 32'h0000_0001)
            if (x.we)
                `CK({mem_wdata_x_o, x.d ? mem_wdata_y_o : x.wy}, {x.wx, x.wy})
        end
        if (x.f == 1)
            `CK(mem_long_o, x.lg)
        if (x.f == 3)
            `CK({ureg_num_o, ureg_data_o}, {1'b0, x.un[6:0], x.wx})
        ptr_cmp();
    endtask : check
    initial
    begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        foreach (mp[a, b])
        begin
            @(posedge mclk_i);
            rnd = lfsr(rnd);
            mp[a][b] = {12'h000, rnd[19:0]};
            mod_load_i <= 1'b1;
            {mod_load_dag_two_i, mod_load_sel_i, mod_load_val_i} <= {a[0], b[2:0], mp[a][b]};
        end
        $display("test modify loads done");
        for (int k = 0; k < 400; k++)
        begin
            @(posedge mclk_i);
            sp = pp;
            r2 = lfsr(rnd);
            rnd = lfsr(r2);
            g = rnd[4];
            ix = rnd[7:5];
            e.f = rnd[1:0];
            {e.d, e.c, e.un} = {rnd[3:2], rnd[4], rnd[19:13]};
            e.we = e.f == 2 || rnd[11];
            e.im = (e.f == 1) ? NORMAL_BASE + {12'h000, r2[19:0]} - pp[g][ix] : r2;
            e.ax = pp[g][ix] + ((e.f == 1) ? e.im : 32'h0000_0000);
            e.lg = rnd[12] && e.ax >= NORMAL_BASE && e.ax < NORMAL_END;
            e.wx = (e.f == 1) ? {rnd[7:0], r2} : ((e.f == 3 && !rnd[20]) ? {8'h00, r2} : {r2, 8'h00});
            e.wy = (e.f == 1) ? {r2[7:0], rnd} : e.wx;
            if (e.f == 2)
                pp[g][ix] = pp[g][ix] + mp[g][rnd[10:8]];
            eq.push_back(e);
            // unknown tops 110 and 111; 110 carries the register form's low field to catch aliasing
            case (e.f)
                0: op_i <= {2'h3, rnd[12] ? 6'h3f : TOP_IREG, rnd[11:4], r2};
                // transfer register field is random; the core keeps no generator map to collide with
                1: op_i <= {TOP_XFER, rnd[4], ix, rnd[11], rnd[12], rnd[19:13], e.im};
                2: op_i <= {TOP_IMEM, 1'b1, ix, rnd[10:8], rnd[4], 5'h00, r2};
                default: op_i <= {2'h0, TOP_IREG, 1'b0, rnd[19:13], r2};
            endcase
            {op_valid_i, mod_load_i, dual_mode_i, ureg_has_comp_i, ureg_wide_i} <= {2'h2, rnd[3:2], rnd[20]};
            {xfer_wdata_x_i, xfer_wdata_y_i} <= {e.wx, e.wy};
            @(negedge mclk_i);
            if (k > 0)
                check(eq.pop_front());
        end
        $display("test random ops done");
        @(posedge mclk_i);
        sp = pp;
        {op_valid_i, rst_i} <= 2'h1;
        @(negedge mclk_i);
        check(eq.pop_front());
        @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        sp = '{default: '0};
        e.f = 0;
        check(e);
        $display("test mid-run reset done");
        stop_test();
    end
    initial
    begin
        repeat (2000) @(posedge mclk_i);
        n_fail++;
        stop_test();
    end
endmodule : tb_top
